// *** rtl/srw_pkg.sv ***
package srw_pkg;
	// Pulse and watchdog times in their own units
	localparam int unsigned RESET_PULSE_MS     = 200;
	localparam int unsigned RESET_MIN_MS       = 140;
	localparam int unsigned WDOG_TIMEOUT_MS    = 1600;
	localparam int unsigned CLK_HZ             = 20000000;
	localparam int unsigned CYCLES_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned RESET_PULSE_CYC    = RESET_PULSE_MS * CYCLES_PER_MS;
	localparam int unsigned RESET_MIN_CYC      = RESET_MIN_MS * CYCLES_PER_MS;
	localparam int unsigned WDOG_TIMEOUT_CYC   = WDOG_TIMEOUT_MS * CYCLES_PER_MS;
	localparam int unsigned CNT_W              = 32;
	localparam logic [1:0]  SYNC_RESET_VAL     = 2'h0;
endpackage

// *** rtl/srw_supervisor.sv ***
`timescale 1ns/1ps
// Contract
// - Manual reset input held low starts a reset pulse.
// - Power-fail output low exactly while power-fail sense shows below threshold.
// - Kick level steady for the full timeout expires watchdog, timeout output low.
// - Floating kick input keeps the watchdog disabled, cleared and idle.
// - Watchdog clears on reset, floating kick, and any kick edge.
// - Once triggered, reset output stays low for the pulse duration.
// - Reset stays low as long as supply-low is active.
// - Full pulse duration is measured from supply recovery or manual release.
// - Watchdog expiry never asserts reset by itself.
// - Timeout output stays low after expiry until the watchdog clears.
// - Timeout output also low whenever supply-low is active.
// - Timeout output returns high with no added delay when supply recovers.
// - Active-high reset is always the exact complement of active-low reset.
// - Retrigger during a pulse keeps reset for at least the minimum duration.
// - After reset ends, first kick edge starts a fresh countdown; each edge restarts.
module srw_supervisor
#(
	parameter int unsigned RESET_CYC = srw_pkg::RESET_PULSE_CYC,
	parameter int unsigned WDOG_CYC  = srw_pkg::WDOG_TIMEOUT_CYC
)
(
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic manual_reset_n,
	input  wire logic supply_low,
	input  wire logic power_fail_sense_in,
	input  wire logic watchdog_kick_in,
	input  wire logic watchdog_kick_float,
	output logic      reset_out_n,
	output logic      reset_out,
	output logic      power_fail_out_n,
	output logic      watchdog_expired_out_n
);
	localparam logic [srw_pkg::CNT_W-1:0] RST_LAST = srw_pkg::CNT_W'(RESET_CYC - 1);
	localparam logic [srw_pkg::CNT_W-1:0] WD_LAST  = srw_pkg::CNT_W'(WDOG_CYC - 1);

	typedef struct packed {
		logic                      rst_active;
		logic [srw_pkg::CNT_W-1:0] rst_cnt;
		logic                      wd_armed;
		logic [srw_pkg::CNT_W-1:0] wd_cnt;
		logic                      wd_expired;
		logic                      kick_prev;
		logic                      rst_n;
		logic                      rst_hi;
		logic                      pf_out_n;
		logic                      wd_out_n;
	} srw_state_s;

	srw_state_s state;
	srw_state_s next_state;
	logic       kick_sync;
	logic       float_sync;
	logic       kick_edge;
	logic       wd_clear;
	logic       trigger;

	// Kick level and its float flag cross separately
	srw_sync u_kick_sync
	(
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.din     (watchdog_kick_in),
		.dout    (kick_sync)
	);

	srw_sync u_float_sync
	(
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.din     (watchdog_kick_float),
		.dout    (float_sync)
	);

	assign kick_edge = kick_sync ^ state.kick_prev;
	// Only the manual input and supply-low trigger reset; expiry is kept out
	assign trigger   = !manual_reset_n || supply_low;
	assign wd_clear  = state.rst_active || float_sync || kick_edge;

	always_comb
	begin
		next_state = state;
		next_state.kick_prev = kick_sync;

		// Counter restarts while a trigger is held, so the full pulse runs from
		// its release; a retrigger therefore always exceeds the minimum
		if (trigger)
		begin
			next_state.rst_active = 1'b1;
			next_state.rst_cnt    = '0;
		end
		else if (state.rst_active)
		begin
			if (state.rst_cnt >= RST_LAST)
				next_state.rst_active = 1'b0;
			else
				next_state.rst_cnt = state.rst_cnt + 1'b1;
		end

		// Watchdog idles until the first edge after reset, then counts
		if (state.rst_active || float_sync)
		begin
			next_state.wd_armed   = 1'b0;
			next_state.wd_cnt     = '0;
			next_state.wd_expired = 1'b0;
		end
		else if (kick_edge)
		begin
			next_state.wd_armed   = 1'b1;
			next_state.wd_cnt     = '0;
			next_state.wd_expired = 1'b0;
		end
		else if (state.wd_armed && !state.wd_expired)
		begin
			if (state.wd_cnt >= WD_LAST)
				next_state.wd_expired = 1'b1;
			else
				next_state.wd_cnt = state.wd_cnt + 1'b1;
		end

		next_state.rst_n = !next_state.rst_active;
		next_state.rst_hi = next_state.rst_active;
		next_state.pf_out_n = !power_fail_sense_in;
		// Supply-low pulls it low; no stretch on recovery
		next_state.wd_out_n = !(next_state.wd_expired || supply_low);
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			state            <= '0;
			state.rst_active <= 1'b1;
			state.rst_hi     <= 1'b1;
			state.pf_out_n   <= 1'b1;
			state.wd_out_n   <= 1'b1;
		end
		else
			state <= next_state;
	end

	assign reset_out_n            = state.rst_n;
	assign reset_out              = state.rst_hi;
	assign power_fail_out_n       = state.pf_out_n;
	assign watchdog_expired_out_n = state.wd_out_n;

	sequence trig_seen_s;
		trigger;
	endsequence

	sequence reset_low_s;
		!reset_out_n;
	endsequence

	property trig_forces_reset_p;
		@(posedge clk_sys) disable iff (!resetn) trig_seen_s |=> reset_low_s;
	endproperty

	manual_reset_a: assert property (trig_forces_reset_p)
		else $error("Trigger did not assert reset");

	pfail_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		power_fail_out_n == !$past(power_fail_sense_in))
		else $error("Power-fail output mismatch");

	expire_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(state.wd_expired) |-> !watchdog_expired_out_n)
		else $error("Expiry did not drive timeout low");

	expiry_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(state.wd_expired) |-> $past(state.wd_cnt) == WD_LAST)
		else $error("Watchdog expired before its full count");

	float_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		float_sync |=> !state.wd_armed && state.wd_cnt == '0)
		else $error("Watchdog active while kick floats");

	edge_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		wd_clear |=> state.wd_cnt == '0 && !state.wd_expired)
		else $error("Watchdog not cleared");

	kick_arm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		kick_edge && !state.rst_active && !float_sync
		|=> state.wd_armed && state.wd_cnt == '0)
		else $error("Kick edge did not restart the countdown");

	expired_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		!watchdog_expired_out_n && !wd_clear && !supply_low |=> !watchdog_expired_out_n)
		else $error("Timeout output released before a clear");

	pulse_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(trigger) |=> !reset_out_n [*8])
		else $error("Reset released too early");

	release_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(reset_out_n) |-> $past(state.rst_cnt) == RST_LAST)
		else $error("Reset released before the full pulse");

	retrigger_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		trigger && state.rst_active |=> !reset_out_n && state.rst_cnt == '0)
		else $error("Retrigger did not restart the pulse");

	supply_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		supply_low |=> !reset_out_n && !watchdog_expired_out_n)
		else $error("Supply-low did not hold outputs low");

	expiry_isolated_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(state.wd_expired) && !$past(trigger) && !trigger
		|-> reset_out_n ##1 reset_out_n)
		else $error("Watchdog expiry asserted reset");

	reset_complement_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		reset_out == !reset_out_n)
		else $error("Reset outputs not complementary");

	timeout_recover_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(supply_low) |=> watchdog_expired_out_n)
		else $error("Timeout output delayed on recovery");

	sequence kick_moved_s;
		$changed(watchdog_kick_in);
	endsequence

	kick_sync_a: assert property (@(posedge clk_sys) disable iff (!resetn)
		kick_moved_s |-> ##2 kick_sync == $past(watchdog_kick_in, 2))
		else $error("Kick level not seen after two stages");
endmodule

// *** rtl/srw_sync.sv ***
`timescale 1ns/1ps
// Two-flop level synchroniser; the first stage feeds only the second
module srw_sync
(
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic [1:0] stage;
	} srw_sync_s;

	srw_sync_s state;
	srw_sync_s next_state;

	always_comb
	begin
		next_state       = state;
		next_state.stage = {state.stage[0], din};
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			state.stage <= srw_pkg::SYNC_RESET_VAL;
		else
			state <= next_state;
	end

	assign dout = state.stage[1];
endmodule

// *** testbench/srw_host_model.sv ***
`timescale 1ns/1ps
// Host side: kicks only while out of reset, as a real processor would
module srw_host_model
#(
	parameter int unsigned HALF = 10
)
(
	input  wire logic clk_sys,
	input  wire logic reset_out_n,
	input  wire logic kick_en,
	output logic      watchdog_kick_in
);
	int unsigned cnt   = 0;
	logic        level = 1'b0;

	assign watchdog_kick_in = level;

	always @(posedge clk_sys)
	begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (kick_en && reset_out_n && cnt == HALF - 1)
			level <= ~level;
	end
endmodule

// *** testbench/supervisor_reset_watchdog_tb.sv ***
`timescale 1ns/1ps
module supervisor_reset_watchdog_tb;
	localparam int unsigned RC = 20;
	localparam int unsigned WC = 50;
	logic clk_sys             = 1'b0;
	logic resetn              = 1'b0;
	logic manual_reset_n      = 1'b1;
	logic supply_low          = 1'b0;
	logic power_fail_sense_in = 1'b0;
	logic watchdog_kick_float = 1'b0;
	logic kick_en             = 1'b0;
	logic watchdog_kick_in;
	logic reset_out_n;
	logic reset_out;
	logic power_fail_out_n;
	logic watchdog_expired_out_n;
	int   err_total           = 0;
	int   check_count         = 0;
	int   cyc_total           = 0;
	always #25 clk_sys = ~clk_sys;
	srw_supervisor #(.RESET_CYC(RC), .WDOG_CYC(WC)) u_dut
	(
		.clk_sys(clk_sys), .resetn(resetn), .manual_reset_n(manual_reset_n),
		.supply_low(supply_low), .power_fail_sense_in(power_fail_sense_in),
		.watchdog_kick_in(watchdog_kick_in), .watchdog_kick_float(watchdog_kick_float),
		.reset_out_n(reset_out_n), .reset_out(reset_out),
		.power_fail_out_n(power_fail_out_n), .watchdog_expired_out_n(watchdog_expired_out_n)
	);
	srw_host_model u_host
	(
		.clk_sys(clk_sys), .reset_out_n(reset_out_n), .kick_en(kick_en),
		.watchdog_kick_in(watchdog_kick_in)
	);
	// Sample on the falling edge so the rising-edge updates have landed
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic chk(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic t_manual;
		@(posedge clk_sys) manual_reset_n <= 1'b0;
		cyc(3);
		chk(reset_out_n, 1'b0);
		chk(reset_out, 1'b1);
		@(posedge clk_sys) manual_reset_n <= 1'b1;
		cyc(RC / 2);
		@(posedge clk_sys) manual_reset_n <= 1'b0;
		@(posedge clk_sys) manual_reset_n <= 1'b1;
		cyc(RC - 2);
		chk(reset_out_n, 1'b0);
		cyc(6);
		chk(reset_out_n, 1'b1);
		chk(reset_out, 1'b0);
		$display("manual reset test done");
	endtask
	task automatic t_pfo;
		@(posedge clk_sys) power_fail_sense_in <= 1'b1;
		cyc(2);
		chk(power_fail_out_n, 1'b0);
		@(posedge clk_sys) power_fail_sense_in <= 1'b0;
		cyc(2);
		chk(power_fail_out_n, 1'b1);
		$display("power fail test done");
	endtask
	task automatic t_wdog;
		@(posedge clk_sys) kick_en <= 1'b1;
		cyc(4 * WC);
		chk(watchdog_expired_out_n, 1'b1);
		@(posedge clk_sys) kick_en <= 1'b0;
		cyc(WC - 15);
		chk(watchdog_expired_out_n, 1'b1);
		cyc(30);
		chk(watchdog_expired_out_n, 1'b0);
		cyc(20);
		chk(watchdog_expired_out_n, 1'b0);
		chk(reset_out_n, 1'b1);
		@(posedge clk_sys) kick_en <= 1'b1;
		cyc(15);
		chk(watchdog_expired_out_n, 1'b1);
		$display("watchdog test done");
	endtask
	task automatic t_float;
		@(posedge clk_sys) watchdog_kick_float <= 1'b1;
		kick_en <= 1'b0;
		cyc(2 * WC);
		chk(watchdog_expired_out_n, 1'b1);
		@(posedge clk_sys) watchdog_kick_float <= 1'b0;
		$display("float test done");
	endtask
	task automatic t_supply;
		@(posedge clk_sys) supply_low <= 1'b1;
		cyc(2);
		chk(watchdog_expired_out_n, 1'b0);
		cyc(2 * RC);
		chk(reset_out_n, 1'b0);
		@(posedge clk_sys) supply_low <= 1'b0;
		cyc(2);
		chk(watchdog_expired_out_n, 1'b1);
		cyc(RC - 4);
		chk(reset_out_n, 1'b0);
		cyc(8);
		chk(reset_out_n, 1'b1);
		$display("supply test done");
	endtask
	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clk_sys)
	begin
		cyc_total++;
		if (cyc_total == 3000)
		begin
			err_total++;
			complete_run;
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		cyc(RC + 5);
		chk(reset_out_n, 1'b1);
		t_manual;
		t_pfo;
		t_wdog;
		t_float;
		t_supply;
		complete_run;
	end
endmodule
